// ### hdl/pcs_flow_core.sv
// ****************************************************************
// Program flow and indirect addressing
// ****************************************************************

// Operation
// - The program counter is thirteen bits wide.
// - Only the low byte is directly readable and writable; upper bits come from the latch.
// - A low-byte write copies latch bits 4 to 0 into the upper counter bits.
// - Call and jump take the top two counter bits from latch bits 4 to 3.
// - Every reset clears the whole program counter.
// - The return stack holds eight hidden thirteen-bit entries.
// - Calls and interrupt vectoring push the counter.
// - A return pops the stack into the counter.
// - Push and pop leave the high latch untouched.
// - The stack is circular and the ninth push overwrites the first.
// - Overflow and underflow wrap silently with no status.
// - The indirect port has no storage and accesses the pointed location.
// - Reading the port through itself returns zero.
// - Writing the port through itself stores nothing.
// - The indirect address is the bank bit above the eight-bit pointer.
module pcs_flow_core
    import pcs_pkg::*;
#(
    parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Flow request from the decoder.
    input wire logic [6:0] flow_op,
    input wire logic [10:0] address_operand,
    input wire logic [7:0] low_byte_wdata,
    input wire logic latch_we,
    input wire logic [4:0] latch_wdata,
    // Program counter view.
    output logic [12:0] program_counter,
    output logic [7:0] pc_low_byte,
    output logic [4:0] pc_high_latch,
    // Indirect access from the decoder.
    input wire logic [7:0] file_select_pointer,
    input wire logic [7:0] status_byte,
    input wire logic ind_rd,
    input wire logic ind_wr,
    input wire logic [7:0] ind_wdata,
    output logic [7:0] ind_rdata,
    // Data memory side.
    output logic [8:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);

    // ****************************************************************
    // Counter and latch
    // ****************************************************************

    pcs_stack_if sif ();

    logic [12:0] pc;
    logic [12:0] next_pc;
    logic [4:0] latch;
    logic [4:0] next_latch;
    logic [12:0] pc_plus;
    pcs_op_e op;

    assign op = pcs_op_e'(flow_op);
    assign pc_plus = 13'(pc + 1'b1);

    // Chooses the next counter value from the requested operation.
    always_comb begin
        next_pc = pc_plus;
        sif.push = 1'b0;
        sif.pop = 1'b0;
        sif.push_data = pc_plus;
        case (op)
            PCS_OP_STEP: begin
                next_pc = pc_plus;
            end
            PCS_OP_CALL: begin
                sif.push = 1'b1;
                next_pc = {latch[4:3], address_operand};
            end
            PCS_OP_JUMP: begin
                next_pc = {latch[4:3], address_operand};
            end
            PCS_OP_RETURN: begin
                sif.pop = 1'b1;
                next_pc = sif.top_data;
            end
            PCS_OP_IRQ: begin
                sif.push = 1'b1;
                sif.push_data = pc;
                next_pc = IRQ_VECTOR;
            end
            PCS_OP_HOLD: begin
                next_pc = pc;
            end
            PCS_OP_LOWWR: begin
                next_pc = {latch, low_byte_wdata};
            end
            default: begin
                next_pc = pc_plus;
            end
        endcase
    end

    // The latch changes only by its own write, never by stack traffic.
    always_comb begin
        next_latch = latch;
        if (latch_we) begin
            next_latch = latch_wdata;
        end
    end

    // Counter and latch registers, cleared on reset.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pc <= PC_RESET;
            latch <= LATCH_RESET;
        end else begin
            pc <= next_pc;
            latch <= next_latch;
        end
    end

    assign program_counter = pc;
    assign pc_low_byte = pc[7:0];
    assign pc_high_latch = latch;

    pcs_return_stack #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .clock(clock),
        .resetn(resetn),
        .sif(sif)
    );

    // ****************************************************************
    // Indirect access
    // ****************************************************************

    logic self_sel;
    logic self_rd_q;

    // Bank bit sits above the pointer to form the data address.
    assign mem_addr = {status_byte[BANK_BIT_POS], file_select_pointer};
    assign self_sel = file_select_pointer == INDIRECT_PORT_ADDR;
    assign mem_rd = ind_rd && !self_sel;
    assign mem_wr = ind_wr && !self_sel;
    assign mem_wdata = ind_wdata;

    // Records whether the previous cycle read the port through itself.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            self_rd_q <= 1'b0;
        end else begin
            self_rd_q <= ind_rd && self_sel;
        end
    end

    // Read data is the pointed location, or zero after a read of the port through itself.
    assign ind_rdata = self_rd_q ? SELF_READ_VALUE : mem_rdata;

    // ****************************************************************
    // Checks
    // ****************************************************************

    a_reset_clear: assert property (@(posedge clock)
        !resetn |=> pc == PC_RESET)
        else $error("Counter not cleared by reset.");
    a_low_write: assert property (@(posedge clock) disable iff (!resetn)
        op == PCS_OP_LOWWR |=> pc == {$past(latch), $past(low_byte_wdata)})
        else $error("Low byte write loaded wrong counter.");
    a_call_target: assert property (@(posedge clock) disable iff (!resetn)
        op == PCS_OP_CALL || op == PCS_OP_JUMP
        |=> pc == {$past(latch[4:3]), $past(address_operand)})
        else $error("Call or jump target wrong.");
    a_call_return: assert property (@(posedge clock) disable iff (!resetn)
        op == PCS_OP_CALL ##1 op == PCS_OP_RETURN
        |=> pc == 13'($past(pc, 2) + 1'b1))
        else $error("Return did not restore the caller.");
    a_latch_kept: assert property (@(posedge clock) disable iff (!resetn)
        (sif.push || sif.pop) && !latch_we |=> $stable(latch))
        else $error("Stack traffic changed the latch.");
    a_self_write: assert property (@(posedge clock) disable iff (!resetn)
        ind_wr && file_select_pointer == 8'h00 |-> !mem_wr)
        else $error("Self write reached memory.");
    a_self_read: assert property (@(posedge clock) disable iff (!resetn)
        ind_rd && self_sel |=> ind_rdata == 8'h00)
        else $error("Self read not zero.");
    a_bank_addr: assert property (@(posedge clock) disable iff (!resetn)
        mem_rd |-> mem_addr[8] == status_byte[7])
        else $error("Bank bit missing from address.");
    a_irq_push: assert property (@(posedge clock) disable iff (!resetn)
        op == PCS_OP_IRQ |-> sif.push ##1 pc == IRQ_VECTOR)
        else $error("Interrupt did not push and vector.");

    c_call: cover property (@(posedge clock) disable iff (!resetn)
        op == PCS_OP_CALL ##[1:20] op == PCS_OP_RETURN);
    c_irq: cover property (@(posedge clock) disable iff (!resetn) op == PCS_OP_IRQ);
    c_lowwr: cover property (@(posedge clock) disable iff (!resetn) op == PCS_OP_LOWWR);
    c_self: cover property (@(posedge clock) disable iff (!resetn) ind_rd && self_sel);
endmodule

// ### hdl/pcs_pkg.sv
package pcs_pkg;

    // ****************************************************************
    // Widths and constants
    // ****************************************************************

    // Program counter width.
    localparam int PC_WIDTH = 13;
    // Width of the low byte and of the file-select pointer.
    localparam int BYTE_WIDTH = 8;
    // Number of return stack entries.
    localparam int STACK_DEPTH = 8;
    // Width of an indirect data address.
    localparam int DATA_ADDR_WIDTH = 9;
    // Width of the address operand of call and jump.
    localparam int OPERAND_WIDTH = 11;
    // Bank select position in the status byte.
    localparam int BANK_BIT_POS = 7;
    // Direct address of the indirect data port in a bank.
    localparam logic [7:0] INDIRECT_PORT_ADDR = 8'h00;
    // Program counter value after reset.
    localparam logic [12:0] PC_RESET = 13'h0000;
    // High latch value after reset.
    localparam logic [4:0] LATCH_RESET = 5'h00;
    // Read value of the port read through itself.
    localparam logic [7:0] SELF_READ_VALUE = 8'h00;

    // Flow operation requested by the decoder, one-hot.
    typedef enum logic [6:0] {
        PCS_OP_STEP   = 7'h01,
        PCS_OP_CALL   = 7'h02,
        PCS_OP_JUMP   = 7'h04,
        PCS_OP_RETURN = 7'h08,
        PCS_OP_IRQ    = 7'h10,
        PCS_OP_HOLD   = 7'h20,
        PCS_OP_LOWWR  = 7'h40
    } pcs_op_e;

endpackage

// ### hdl/pcs_stack_if.sv
// Carries push and pop requests between the counter logic and the stack.
interface pcs_stack_if;
    import pcs_pkg::*;
    logic push;
    logic pop;
    logic [PC_WIDTH-1:0] push_data;
    logic [PC_WIDTH-1:0] top_data;
    modport ctrl (output push, output pop, output push_data, input top_data);
    modport stack (input push, input pop, input push_data, output top_data);
endinterface

// ### hdl/pcs_return_stack.sv
// Circular return stack with a hidden pointer.
module pcs_return_stack
    import pcs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Stack requests.
    pcs_stack_if.stack sif
);
    localparam int PW = $clog2(DEPTH);

    // Refuses a depth that the wrapping pointer cannot serve.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("Stack depth must be a power of two.");
    end

    logic [PC_WIDTH-1:0] entry [DEPTH];
    logic [PC_WIDTH-1:0] next_entry [DEPTH];
    logic [PW-1:0] ptr;
    logic [PW-1:0] next_ptr;

    // Pointer wraps silently in both directions, no overflow flag exists.
    always_comb begin
        next_ptr = ptr;
        if (sif.push) begin
            next_ptr = PW'(ptr + 1'b1);
        end else if (sif.pop) begin
            next_ptr = PW'(ptr - 1'b1);
        end
    end

    // The ninth push overwrites the oldest slot.
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_entry
            always_comb begin
                next_entry[i] = entry[i];
                if (sif.push && PW'(ptr + 1'b1) == PW'(i)) begin
                    next_entry[i] = sif.push_data;
                end
            end
            always_ff @(posedge clock) begin
                entry[i] <= next_entry[i];
            end
        end
    endgenerate

    // Pointer register.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ptr <= '0;
        end else begin
            ptr <= next_ptr;
        end
    end

    assign sif.top_data = entry[ptr];

    a_stack_wrap: assert property (@(posedge clock) disable iff (!resetn)
        sif.push && !sif.pop |=> ptr == PW'($past(ptr) + 1'b1))
        else $error("Stack pointer did not advance on push.");
    a_push_pop_top: assert property (@(posedge clock) disable iff (!resetn)
        sif.push |=> !sif.pop || sif.top_data == $past(sif.push_data))
        else $error("Pop did not return the last pushed value.");
endmodule

// ### verification/pcs_mem_model.sv
// ****************************************************************
// Data memory seen through the indirect port
// ****************************************************************
module pcs_mem_model (
    // Clock.
    input wire logic clock,
    // Access from the core.
    input wire logic [8:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    // Read answer.
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [512];
    logic [7:0] rd_q = 8'h00;
    logic rd_v = 1'b0;

    // Stores writes and answers a read one cycle after it is asked.
    always @(posedge clock) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        rd_v <= mem_rd;
        if (mem_rd) begin
            rd_q <= mem[mem_addr];
        end
    end

    // Between answers the bus shows the inverse, so a stale value never matches.
    assign mem_rdata = rd_v ? rd_q : ~rd_q;
endmodule

// ### verification/pc_stack_indirect_addressing_tb_top.sv
// ****************************************************************
// Program flow and indirect access bench
// ****************************************************************
module pc_stack_indirect_addressing_tb_top
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [12:0] IRQ_VEC = 13'h0004;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [6:0] flow_op = PCS_OP_HOLD;
    logic [10:0] address_operand = 11'h000;
    logic [7:0] low_byte_wdata = 8'h00;
    logic latch_we = 1'b0;
    logic [4:0] latch_wdata = 5'h00;
    logic [7:0] file_select_pointer = 8'h00;
    logic [7:0] status_byte = 8'h00;
    logic ind_rd = 1'b0;
    logic ind_wr = 1'b0;
    logic [7:0] ind_wdata = 8'h00;
    logic [12:0] program_counter;
    logic [7:0] pc_low_byte, ind_rdata, mem_wdata, mem_rdata;
    logic [4:0] pc_high_latch;
    logic [8:0] mem_addr;
    logic mem_rd, mem_wr;
    int n_errors = 0;
    int checks = 0;

    pcs_flow_core #(.IRQ_VECTOR(IRQ_VEC)) u_dut (.clock(clock), .resetn(resetn),
        .flow_op(flow_op), .address_operand(address_operand),
        .low_byte_wdata(low_byte_wdata), .latch_we(latch_we), .latch_wdata(latch_wdata),
        .program_counter(program_counter), .pc_low_byte(pc_low_byte),
        .pc_high_latch(pc_high_latch), .file_select_pointer(file_select_pointer),
        .status_byte(status_byte), .ind_rd(ind_rd), .ind_wr(ind_wr), .ind_wdata(ind_wdata),
        .ind_rdata(ind_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    pcs_mem_model u_mem (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    // Free-running 8 ns clock.
    initial begin
        forever #4 clock = ~clock;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp(input logic [12:0] got, input logic [12:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Applies one flow request; the counter is settled at the next falling edge.
    task automatic step(input logic [6:0] op, input logic [10:0] opnd);
        flow_op = op;
        address_operand = opnd;
        @(negedge clock);
    endtask

    task automatic set_latch(input logic [4:0] v);
        flow_op = PCS_OP_HOLD;
        latch_we = 1'b1;
        latch_wdata = v;
        @(negedge clock);
        latch_we = 1'b0;
    endtask

    // One indirect access; a read is judged one cycle after it is asked.
    task automatic ind_rw(input logic wr, input logic [7:0] ptr, input logic bank,
                          input logic [7:0] wd, input logic [7:0] exp);
        file_select_pointer = ptr;
        status_byte = {bank, 7'h00};
        ind_wr = wr;
        ind_rd = !wr;
        ind_wdata = wd;
        #1;
        cmp(mem_addr, {bank, ptr}, "indirect address");
        cmp(wr ? mem_wr : mem_rd, ptr != 8'h00, "memory strobe");
        @(negedge clock);
        ind_wr = 1'b0;
        ind_rd = 1'b0;
        if (!wr) begin
            cmp(ind_rdata, exp, "indirect read data");
        end
        @(negedge clock);
    endtask

    task automatic t_reset;
        cmp(program_counter, PC_RESET, "counter after reset");
        set_latch(5'h1f);
        step(PCS_OP_STEP, 11'h000);
        step(7'h00, 11'h000);
        step(PCS_OP_HOLD, 11'h000);
        cmp(program_counter, 13'h0002, "counter step and unknown code");
        resetn = 1'b0;
        @(negedge clock);
        resetn = 1'b1;
        cmp(program_counter, PC_RESET, "counter after second reset");
        cmp(pc_high_latch, LATCH_RESET, "latch after reset");
        $display("test reset done");
    endtask

    task automatic t_lowwr;
        set_latch(5'h1b);
        low_byte_wdata = 8'h5a;
        step(PCS_OP_LOWWR, 11'h000);
        cmp(program_counter, 13'h1b5a, "low byte write");
        cmp(pc_low_byte, 8'h5a, "low byte view");
        set_latch(5'h1f);
        low_byte_wdata = 8'hff;
        step(PCS_OP_LOWWR, 11'h000);
        step(PCS_OP_STEP, 11'h000);
        cmp(program_counter, 13'h0000, "counter wraps at 13 bits");
        $display("test low byte done");
    endtask

    task automatic t_call;
        set_latch(5'h18);
        low_byte_wdata = 8'h40;
        step(PCS_OP_LOWWR, 11'h000);
        step(PCS_OP_CALL, 11'h2a5);
        cmp(program_counter, 13'h1aa5, "call target");
        cmp(pc_high_latch, 5'h18, "latch after push");
        step(PCS_OP_RETURN, 11'h000);
        cmp(program_counter, 13'h1841, "return address");
        cmp(pc_high_latch, 5'h18, "latch after pop");
        set_latch(5'h08);
        step(PCS_OP_JUMP, 11'h123);
        step(PCS_OP_HOLD, 11'h000);
        cmp(program_counter, 13'h0923, "jump target and hold");
        $display("test call done");
    endtask

    task automatic t_wrap;
        set_latch(5'h00);
        for (int i = 1; i <= 9; i++) begin
            step(PCS_OP_CALL, 11'(i * 16));
        end
        for (int i = 8; i >= 1; i--) begin
            step(PCS_OP_RETURN, 11'h000);
            cmp(program_counter, 13'(i * 16 + 1), "nested return");
        end
        step(PCS_OP_RETURN, 11'h000);
        cmp(program_counter, 13'h0081, "underflow wraps");
        $display("test stack wrap done");
    endtask

    task automatic t_irq;
        step(PCS_OP_JUMP, 11'h777);
        step(PCS_OP_IRQ, 11'h000);
        cmp(program_counter, IRQ_VEC, "interrupt vector");
        step(PCS_OP_STEP, 11'h000);
        step(PCS_OP_RETURN, 11'h000);
        step(PCS_OP_HOLD, 11'h000);
        cmp(program_counter, 13'h0777, "return from interrupt");
        $display("test interrupt done");
    endtask

    task automatic t_ind;
        ind_rw(1'b1, 8'h20, 1'b1, 8'h3c, 8'h00);
        ind_rw(1'b1, 8'h20, 1'b0, 8'hc3, 8'h00);
        ind_rw(1'b0, 8'h20, 1'b1, 8'h00, 8'h3c);
        ind_rw(1'b0, 8'h20, 1'b0, 8'h00, 8'hc3);
        ind_rw(1'b1, 8'h00, 1'b0, 8'h77, 8'h00);
        ind_rw(1'b0, 8'h00, 1'b0, 8'h00, SELF_READ_VALUE);
        $display("test indirect done");
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        t_reset();
        t_lowwr();
        t_call();
        t_wrap();
        t_irq();
        t_ind();
        end_of_test();
    end

    // Watchdog at 5000 cycles, well beyond the roughly 65 cycles the tests need.
    initial begin
        #(5000 * 8);
        n_errors++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule
